// ==== verilog/psr_top.sv ====
// pressure setpoint relays: front panel editing, host access, relay drive
//
// Summary of operation
// - select button cycles operation, setpoints, operation
// - show setpoint value, flash its led
// - up/down keys adjust the shown setpoint
// - lock switch blocks key edits
// - scrolling past range end flips polarity
// - select press commits edit, shows next setpoint or operation
// - relay on above (+) or below (-) setpoint
// - release after fixed 10% return band
// - four setpoints reset to zero, negative
// - host commands take channels 1 to 4 on the full option, 1 to 2 on the base
// - hysteresis fixed, no adjustment anywhere
// - base option: two independent relay channels
`timescale 1ns/100ps
`include "psr_regs.svh"

module psr_top #(
   parameter int          PW           = 16,
   parameter int          NCH          = `PSR_NCH_FULL,
   parameter logic [15:0] SP_MAX       = 16'hFFFF,
   parameter int          BLINK_CYCLES = `PSR_BLINK_MS * 1000
                                         * `PSR_CLK_MHZ * 1000 / 1000
) (
   // clock, reset, enable
   input  wire logic           clk,
   input  wire logic           reset,
   input  wire logic           ce,
   // apb slave
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [7:0]     paddr,
   input  wire logic [31:0]    pwdata,
   output logic      [31:0]    prdata,
   output logic                pready,
   output logic                pslverr,
   // pressure measurement
   input  wire logic [PW-1:0]  pressure,
   input  wire logic           pressure_valid,
   // front panel controls
   input  wire logic           sp_button,
   input  wire logic           up_key,
   input  wire logic           down_key,
   input  wire logic           lock_sw,
   // front panel indication
   output logic      [PW-1:0]  display_value,
   output logic                display_sp,
   output logic      [NCH-1:0] sp_led,
   // relay drive
   output logic      [NCH-1:0] relay
);
   localparam int IW = $clog2(NCH);
   localparam int BW = $clog2(BLINK_CYCLES + 1);
   localparam logic [PW-1:0] VMAX = SP_MAX[PW-1:0];

   // valid host channel selector for the current variant
   function automatic logic chan_ok(input logic [`PSR_SEL_W-1:0] s,
                                    input logic four);
      chan_ok = (s >= `PSR_SEL_W'(1)) &&
                (s <= (four ? `PSR_SEL_W'(`PSR_NCH_FULL)
                            : `PSR_SEL_W'(`PSR_NCH_BASE)));
   endfunction

   // channel index shown in a setpoint display state
   function automatic logic [IW-1:0] disp_idx(input psr_pkg::psr_disp_e d);
      case (d)
         psr_pkg::DS_SP2: disp_idx = IW'(1);
         psr_pkg::DS_SP3: disp_idx = IW'(2);
         psr_pkg::DS_SP4: disp_idx = IW'(3);
         default:         disp_idx = IW'(0);
      endcase
   endfunction

   // state
   psr_pkg::psr_disp_e          disp_reg;
   psr_pkg::psr_disp_e          disp_next;
   logic [PW-1:0]               sp_val_reg [NCH];
   logic [NCH-1:0]              sp_neg_reg;
   logic [PW-1:0]               edit_val_reg;
   logic [PW-1:0]               edit_val_next;
   logic                        edit_neg_reg;
   logic                        edit_neg_next;
   logic                        four_reg;
   logic [`PSR_SEL_W-1:0]       hsel_reg;
   logic                        err_reg;
   logic [PW-1:0]               press_reg;
   logic                        btn_prev_reg;
   logic                        up_prev_reg;
   logic                        dn_prev_reg;
   logic [BW-1:0]               blink_cnt_reg;
   logic                        blink_reg;
   logic                        pready_reg;
   logic                        pslverr_reg;
   logic [31:0]                 prdata_reg;
   logic [PW-1:0]               disp_val_reg;
   logic                        disp_sp_reg;
   logic [NCH-1:0]              led_reg;
   logic [NCH-1:0]              relay_reg;

   // panel events, edge detected; inputs are already synchronous
   logic          sel_ev;
   logic          up_ev;
   logic          dn_ev;
   logic          in_sp;
   logic          commit;
   logic [IW-1:0] cur_idx;
   logic [IW-1:0] nxt_idx;
   logic [NCH-1:0] active_mask;

   assign in_sp   = (disp_reg != psr_pkg::DS_RUN);
   assign sel_ev  = sp_button & ~btn_prev_reg;
   assign up_ev   = up_key   & ~up_prev_reg & ~lock_sw & in_sp & ~sel_ev;
   assign dn_ev   = down_key & ~dn_prev_reg & ~lock_sw & in_sp & ~sel_ev
                    & ~up_ev;
   // leaving a setpoint stores the edit
   assign commit  = sel_ev & in_sp;
   assign cur_idx = disp_idx(disp_reg);
   assign nxt_idx = disp_idx(disp_next);

   // select button sequence, length by variant
   always_comb begin
      disp_next = disp_reg;
      if (sel_ev) begin
         case (disp_reg)
            psr_pkg::DS_RUN: disp_next = psr_pkg::DS_SP1;
            psr_pkg::DS_SP1: disp_next = psr_pkg::DS_SP2;
            psr_pkg::DS_SP2: disp_next = four_reg ? psr_pkg::DS_SP3
                                                  : psr_pkg::DS_RUN;
            psr_pkg::DS_SP3: disp_next = psr_pkg::DS_SP4;
            default:         disp_next = psr_pkg::DS_RUN;
         endcase
      end
   end

   // step the edit copy; wrap flips polarity instead
   assign edit_val_next =
      (sel_ev && disp_next != psr_pkg::DS_RUN) ? sp_val_reg[nxt_idx] :
      (up_ev && edit_val_reg != VMAX)          ? edit_val_reg + PW'(1) :
      (dn_ev && edit_val_reg != '0)            ? edit_val_reg - PW'(1) :
                                                 edit_val_reg;
   assign edit_neg_next =
      (sel_ev && disp_next != psr_pkg::DS_RUN) ? sp_neg_reg[nxt_idx] :
      ((up_ev && edit_val_reg == VMAX) ||
       (dn_ev && edit_val_reg == '0))          ? ~edit_neg_reg :
                                                 edit_neg_reg;

   // panel state and edit copy
   always_ff @(posedge clk) begin
      if (reset) begin
         disp_reg     <= psr_pkg::DS_RUN;
         edit_val_reg <= PW'(`PSR_RST_VALUE);
         edit_neg_reg <= `PSR_RST_NEG;
         btn_prev_reg <= 1'b0;
         up_prev_reg  <= 1'b0;
         dn_prev_reg  <= 1'b0;
      end else if (ce) begin
         disp_reg     <= disp_next;
         edit_val_reg <= edit_val_next;
         edit_neg_reg <= edit_neg_next;
         btn_prev_reg <= sp_button;
         up_prev_reg  <= up_key;
         dn_prev_reg  <= down_key;
      end
   end

   // apb decode; the answer comes one cycle into the access phase
   logic          acc;
   logic          wr_en;
   logic          hit_ctrl;
   logic          hit_stat;
   logic          hit_sel;
   logic          hit_val;
   logic          hit_pol;
   logic          hit_press;
   logic          mapped;
   logic          hsel_ok;
   logic [IW-1:0] hidx;
   logic          host_val_wr;
   logic          host_pol_wr;
   logic          err_set;
   logic          err_clr;
   logic [31:0]   rd_data;

   assign acc       = psel & penable & ~pready_reg;
   assign wr_en     = psel & penable & pready_reg & pwrite;
   assign hit_ctrl  = (paddr == `PSR_OFF_CTRL);
   assign hit_stat  = (paddr == `PSR_OFF_STATUS);
   assign hit_sel   = (paddr == `PSR_OFF_SEL);
   assign hit_val   = (paddr == `PSR_OFF_VALUE);
   assign hit_pol   = (paddr == `PSR_OFF_POL);
   assign hit_press = (paddr == `PSR_OFF_PRESS);
   assign mapped    = hit_ctrl | hit_stat | hit_sel | hit_val | hit_pol
                      | hit_press;
   // selector 1..4 on the full variant, 1..2 on the base
   assign hsel_ok   = chan_ok(hsel_reg, four_reg);
   assign hidx      = IW'(hsel_reg - `PSR_SEL_W'(1));
   assign host_val_wr = wr_en & hit_val & hsel_ok;
   assign host_pol_wr = wr_en & hit_pol & hsel_ok;
   assign err_set   = wr_en & (hit_val | hit_pol) & ~hsel_ok;
   assign err_clr   = wr_en & hit_stat & pwdata[`PSR_STAT_ERR_BIT];

   // read mux; reserved bits read zero
   assign rd_data =
      hit_ctrl  ? 32'(four_reg) :
      hit_stat  ? (32'(relay_reg)
                   | (32'(disp_reg) << `PSR_STAT_DISP_LSB)
                   | (32'(lock_sw) << `PSR_STAT_LOCK_BIT)
                   | (32'(err_reg) << `PSR_STAT_ERR_BIT)) :
      hit_sel   ? 32'(hsel_reg) :
      hit_val   ? (hsel_ok ? 32'(sp_val_reg[hidx]) : 32'h0000_0000) :
      hit_pol   ? (hsel_ok ? 32'(sp_neg_reg[hidx]) : 32'h0000_0000) :
      hit_press ? 32'(press_reg) :
                  32'h0000_0000;

   // apb handshake and answer
   always_ff @(posedge clk) begin
      if (reset) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else if (ce) begin
         pready_reg  <= acc;
         pslverr_reg <= acc & ~mapped;
         prdata_reg  <= (acc & ~pwrite) ? rd_data : 32'h0000_0000;
      end
   end

   // configuration registers; a new error wins over its clear
   always_ff @(posedge clk) begin
      if (reset) begin
         four_reg <= `PSR_RST_FOUR;
         hsel_reg <= `PSR_SEL_W'(`PSR_RST_SEL);
         err_reg  <= 1'b0;
      end else if (ce) begin
         if (wr_en && hit_ctrl) begin
            four_reg <= pwdata[`PSR_CTRL_FOUR_BIT];
         end
         if (wr_en && hit_sel) begin
            hsel_reg <= pwdata[`PSR_SEL_W-1:0];
         end
         err_reg <= err_set | (err_reg & ~err_clr);
      end
   end

   // stored setpoints; host write lands after a same-cycle panel commit
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < NCH; i++) begin
            sp_val_reg[i] <= PW'(`PSR_RST_VALUE);
            sp_neg_reg[i] <= `PSR_RST_NEG;
         end
      end else if (ce) begin
         for (int i = 0; i < NCH; i++) begin
            if (commit && cur_idx == IW'(i)) begin
               sp_val_reg[i] <= edit_val_reg;
               sp_neg_reg[i] <= edit_neg_reg;
            end
            if (host_val_wr && hidx == IW'(i)) begin
               sp_val_reg[i] <= pwdata[PW-1:0];
            end
            if (host_pol_wr && hidx == IW'(i)) begin
               sp_neg_reg[i] <= pwdata[`PSR_POL_NEG_BIT];
            end
         end
      end
   end

   // two channels on the base option, four on the full one
   assign active_mask = four_reg ? NCH'('1)
                                 : NCH'((1 << `PSR_NCH_BASE) - 1);

   // per-channel comparators; no hysteresis setting exists
   logic [NCH-1:0] relay_w;
   psr_chan_if #(.PW(PW)) chif [NCH] ();

   for (genvar g = 0; g < NCH; g++) begin : g_chan
      assign chif[g].pressure = pressure;
      assign chif[g].sample   = pressure_valid & active_mask[g];
      assign chif[g].sp_value = sp_val_reg[g];
      assign chif[g].sp_neg   = sp_neg_reg[g];
      assign relay_w[g]       = chif[g].relay;
      psr_channel #(.PW(PW)) u_chan (
         .clk   (clk),
         .reset (reset),
         .ce    (ce),
         .ch    (chif[g])
      );
   end

   // led flash timebase; slow, so the count is a parameter
   always_ff @(posedge clk) begin
      if (reset) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
      end else if (ce) begin
         if (blink_cnt_reg == BW'(BLINK_CYCLES - 1)) begin
            blink_cnt_reg <= '0;
            blink_reg     <= ~blink_reg;
         end else begin
            blink_cnt_reg <= blink_cnt_reg + BW'(1);
         end
      end
   end

   // display, leds and relays, all registered
   logic [NCH-1:0] led_next;
   for (genvar g = 0; g < NCH; g++) begin : g_led
      assign led_next[g] = in_sp & (cur_idx == IW'(g)) & blink_reg;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         press_reg    <= '0;
         disp_val_reg <= '0;
         disp_sp_reg  <= 1'b0;
         led_reg      <= '0;
         relay_reg    <= '0;
      end else if (ce) begin
         if (pressure_valid) begin
            press_reg <= pressure;
         end
         // setpoint replaces pressure in the readout
         disp_val_reg <= in_sp ? edit_val_reg : press_reg;
         disp_sp_reg  <= in_sp;
         led_reg      <= led_next;
         // inactive channels are held released
         relay_reg    <= relay_w & active_mask;
      end
   end

   // outputs
   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;
   assign display_value = disp_val_reg;
   assign display_sp    = disp_sp_reg;
   assign sp_led        = led_reg;
   assign relay         = relay_reg;
endmodule

// ==== verilog/psr_regs.svh ====
// register offsets, field positions and timing constants of the setpoint relays
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH

// apb byte offsets
`define PSR_OFF_CTRL      8'h00
`define PSR_OFF_STATUS    8'h04
`define PSR_OFF_SEL       8'h08
`define PSR_OFF_VALUE     8'h0C
`define PSR_OFF_POL       8'h10
`define PSR_OFF_PRESS     8'h14

// field positions
`define PSR_CTRL_FOUR_BIT 0
`define PSR_STAT_DISP_LSB 4
`define PSR_STAT_LOCK_BIT 8
`define PSR_STAT_ERR_BIT  9
`define PSR_POL_NEG_BIT   0
`define PSR_SEL_W         3

// reset values: zero setpoint, falling-pressure sense
`define PSR_RST_VALUE     0
`define PSR_RST_NEG       1'b1
`define PSR_RST_FOUR      1'b0
`define PSR_RST_SEL       1

// channel counts of the two variants
`define PSR_NCH_BASE      2
`define PSR_NCH_FULL      4

// return hysteresis is one tenth of the setpoint
`define PSR_HYST_DIV      10

// timing: clock rate and led flash half period
`define PSR_CLK_MHZ       100
`define PSR_BLINK_MS      250

`endif

// ==== verilog/psr_pkg.sv ====
// types shared by the setpoint relay block
package psr_pkg;

   // front-panel display state: normal operation or one setpoint shown
   typedef enum logic [2:0] {
      DS_RUN,
      DS_SP1,
      DS_SP2,
      DS_SP3,
      DS_SP4
   } psr_disp_e;

endpackage

// ==== verilog/psr_chan_if.sv ====
// interface between the setpoint controller and one relay channel
`timescale 1ns/100ps

interface psr_chan_if #(
   parameter int PW = 16
);
   logic [PW-1:0] pressure;
   logic          sample;
   logic [PW-1:0] sp_value;
   logic          sp_neg;
   logic          relay;

   modport ctrl (output pressure, output sample, output sp_value,
                 output sp_neg, input relay);
   modport chan (input pressure, input sample, input sp_value,
                 input sp_neg, output relay);
endinterface

// ==== verilog/psr_channel.sv ====
// one setpoint channel: compare with hysteresis and hold the relay state
`timescale 1ns/100ps
`include "psr_regs.svh"

module psr_channel #(
   parameter int PW = 16
) (
   // clock and control
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic ce,
   // link to the controller
   psr_chan_if.chan  ch
);
   localparam logic [PW-1:0] HDIV = PW'(`PSR_HYST_DIV);

   logic          relay_reg;
   logic          relay_next;
   logic [PW-1:0] tenth;
   logic [PW:0]   rel_hi;
   logic [PW-1:0] rel_lo;
   logic          act_w;
   logic          rel_w;

   assign tenth  = ch.sp_value / HDIV;
   assign rel_hi = {1'b0, ch.sp_value} + {1'b0, tenth};
   assign rel_lo = ch.sp_value - tenth;  // tenth never exceeds the setpoint

   assign act_w  = ch.sp_neg ? (ch.pressure < ch.sp_value)
                             : (ch.pressure > ch.sp_value);
   assign rel_w  = ch.sp_neg ? ({1'b0, ch.pressure} >= rel_hi)
                             : (ch.pressure <= rel_lo);

   // evaluate only on a new sample, else hold
   assign relay_next = !ch.sample ? relay_reg :
                       relay_reg  ? !rel_w    : act_w;

   // relay state
   always_ff @(posedge clk) begin
      if (reset) begin
         relay_reg <= 1'b0;
      end else if (ce) begin
         relay_reg <= relay_next;
      end
   end

   assign ch.relay = relay_reg;
endmodule

// ==== dv/psr_top_monitor.sv ====
// port-level assertions of the setpoint relays
`timescale 1ns/100ps

module psr_top_monitor #(
   parameter int          PW     = 16,
   parameter int          NCH    = 4,
   parameter logic [15:0] SP_MAX = 16'hFFFF
) (
   // clock and control
   input wire logic           clk,
   input wire logic           reset,
   input wire logic           ce,
   // apb
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [7:0]     paddr,
   input wire logic [31:0]    pwdata,
   input wire logic [31:0]    prdata,
   input wire logic           pready,
   input wire logic           pslverr,
   // measurement and panel
   input wire logic [PW-1:0]  pressure,
   input wire logic           pressure_valid,
   input wire logic           sp_button,
   input wire logic           up_key,
   input wire logic           down_key,
   input wire logic           lock_sw,
   // outputs
   input wire logic [PW-1:0]  display_value,
   input wire logic           display_sp,
   input wire logic [NCH-1:0] sp_led,
   input wire logic [NCH-1:0] relay
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // one wait state, then the answer
   property p_rdy_wait;
      ce && psel && penable && !pready |=> pready;
   endproperty
   a_rdy_wait: assert property (p_rdy_wait) else $error("no answer");

   // addresses past the map are refused
   property p_bad_addr;
      pready && paddr > 8'h14 |-> pslverr;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("no refusal");

   // relays 0 and 1 move only two edges after a sample
   property p_relay_hold;
      $changed(relay[1:0]) |-> $past(pressure_valid, 2);
   endproperty
   a_relay_hold: assert property (p_relay_hold)
      else $error("relay moved without sample");

   // at most one setpoint led lit
   property p_led_one;
      $onehot0(sp_led);
   endproperty
   a_led_one: assert property (p_led_one) else $error("leds");

   // select from operation shows a setpoint
   property p_sel_enter;
      $rose(sp_button) && !display_sp |-> ##2 display_sp;
   endproperty
   a_sel_enter: assert property (p_sel_enter)
      else $error("select ignored");

   // a locked up key leaves the shown value alone
   property p_lock_hold;
      $rose(up_key) && lock_sw && display_sp
         |=> $stable(display_value)[*3];
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("locked edit");

   // up key steps the shown setpoint by one
   property p_up_step;
      $rose(up_key) && !lock_sw && display_sp && !sp_button
         && display_value < SP_MAX
         |-> ##2 display_value == $past(display_value, 2) + 1;
   endproperty
   a_up_step: assert property (p_up_step)
      else $error("up step wrong");

   // at the range end the value stays put
   property p_scroll_end;
      $rose(up_key) && !lock_sw && display_sp && !sp_button
         && display_value == SP_MAX |-> ##2 display_value == SP_MAX;
   endproperty
   a_scroll_end: assert property (p_scroll_end)
      else $error("range end passed");
endmodule

bind psr_top psr_top_monitor #(.PW(PW), .NCH(NCH), .SP_MAX(SP_MAX))
   i_mon (.clk, .reset, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .pressure, .pressure_valid, .sp_button,
   .up_key, .down_key, .lock_sw, .display_value, .display_sp, .sp_led,
   .relay);

// ==== dv/psr_sense_model.sv ====
// process side model: delivers pressure samples, fast or slow
`timescale 1ns/100ps

module psr_sense_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // request from the bench
   input  wire logic        req,
   input  wire logic        slow,
   input  wire logic [15:0] value,
   // measurement to the block
   output logic      [15:0] pressure,
   output logic             pressure_valid
);
   logic [3:0] wait_reg;

   // bus shows a toggling pattern outside the pulse, so no stale hold
   always_ff @(posedge clk) begin
      if (reset) begin
         wait_reg <= 4'h0;
         pressure_valid <= 1'b0;
         pressure <= 16'h0;
      end else begin
         pressure_valid <= (wait_reg == 4'h1);
         pressure <= (wait_reg == 4'h1) ? value : ~pressure;
         if (req && wait_reg == 4'h0)
            wait_reg <= slow ? 4'h6 : 4'h1;
         else if (wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
      end
   end
endmodule

// ==== dv/test_psr_top.sv ====
// self-checking bench of the setpoint relays
`timescale 1ns/100ps

module test_psr_top;
   localparam logic [15:0] SPM = 16'h0040;
   logic        clk = 0, reset = 1, ce = 1;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, rn;
   logic        pready, pslverr, er, req = 0, slow = 0;
   logic        sp_button = 0, up_key = 0, down_key = 0, lock_sw = 0;
   logic [15:0] pressure, pval = 16'h0, display_value, p;
   logic        pressure_valid, display_sp;
   logic [3:0]  sp_led, relay, ng = 4'hF, st = 4'h0;
   logic [15:0] sp [4] = '{default: 16'h0};
   logic [1:0]  seen;
   int          miscompares = 0, total_checks = 0, cycles = 0, c;
   int          seed = 32'h7995;

   psr_top #(.NCH(4), .SP_MAX(SPM), .BLINK_CYCLES(4)) i_dut (.clk,
      .reset, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pressure, .pressure_valid, .sp_button, .up_key,
      .down_key, .lock_sw, .display_value, .display_sp, .sp_led, .relay);
   psr_sense_model i_feed (.clk, .reset, .req, .slow, .value(pval),
      .pressure, .pressure_valid);

   // free-running clock
   always #5 clk = ~clk;

   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         finish_test;
      end
   end

   task automatic finish_test;
      if (miscompares == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // expected relay state after one sample
   function automatic logic rly(logic on, logic neg, logic [15:0] s,
                                logic [15:0] v);
      if (neg)
         return on ? (v < s + s / 10) : (v < s);
      return on ? (v > s - s / 10) : (v > s);
   endfunction

   // one apb transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no fixed wait: only the hang guard ends a stuck transfer
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // panel press: 0 select, 1 up, 2 down; ends settled
   task automatic press(input int k);
      @(posedge clk);
      if (k == 0) sp_button <= 1'b1;
      else if (k == 1) up_key <= 1'b1;
      else down_key <= 1'b1;
      repeat (3) @(posedge clk);
      sp_button <= 1'b0;
      up_key <= 1'b0;
      down_key <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   // one measurement, then relays against the model
   task automatic meas(input logic [15:0] v);
      int n;
      n = 0;
      rn = $random(seed);
      @(posedge clk);
      req <= 1'b1;
      pval <= v;
      slow <= rn[0];
      @(posedge clk);
      req <= 1'b0;
      do begin
         @(negedge clk);
         n++;
      end while (pressure_valid !== 1'b1 && n < 20);
      repeat (3) @(negedge clk);
      for (int i = 0; i < 4; i++) st[i] = rly(st[i], ng[i], sp[i], v);
      chk({28'h0, relay}, {28'h0, st});
   endtask

   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      apb(0, 8'h20, 0);
      chk({31'h0, er}, 1);
      apb(1, 8'h00, 1);
      // every channel: reset values, then setpoints, random except the fixed one on channel one
      for (c = 0; c < 4; c++) begin
         rn = $random(seed);
         apb(1, 8'h08, c + 1);
         apb(0, 8'h0C, 0);
         chk(rd, 0);
         apb(0, 8'h10, 0);
         chk(rd, 1);
         sp[c] = (c == 0) ? SPM - 16'h1 : {10'h0, rn[5:0]};
         ng[c] = (c == 0) ? 1'b0 : rn[8];
         apb(1, 8'h0C, {16'h0, sp[c]});
         apb(1, 8'h10, {31'h0, ng[c]});
      end
      apb(1, 8'h08, 0);
      apb(1, 8'h0C, 32'h11);
      apb(0, 8'h04, 0);
      chk({31'h0, rd[9]}, 1);
      // panel editing of setpoint one
      press(0);
      chk({31'h0, display_sp}, 1);
      chk({16'h0, display_value}, {16'h0, sp[0]});
      seen = 2'b00;
      repeat (12) begin
         @(negedge clk);
         seen = seen | {sp_led[0], ~sp_led[0]};
      end
      chk({30'h0, seen}, 3);
      press(1);
      chk({16'h0, display_value}, {16'h0, SPM});
      press(1);
      chk({16'h0, display_value}, {16'h0, SPM});
      @(posedge clk);
      lock_sw <= 1'b1;
      press(1);
      chk({16'h0, display_value}, {16'h0, SPM});
      @(posedge clk);
      lock_sw <= 1'b0;
      press(2);
      chk({16'h0, display_value}, {16'h0, SPM - 16'h1});
      press(0);
      chk({16'h0, display_value}, {16'h0, sp[1]});
      press(0);
      press(0);
      press(0);
      chk({31'h0, display_sp}, 0);
      apb(1, 8'h08, 1);
      apb(0, 8'h0C, 0);
      chk(rd, {16'h0, SPM - 16'h1});
      apb(0, 8'h10, 0);
      chk(rd, 1);
      ng[0] = 1'b1;
      // random and boundary pressures on random channels
      for (int i = 0; i < 80; i++) begin
         rn = $random(seed);
         c = rn[9:8];
         p = (rn[11:10] == 0) ? sp[c] :
             (rn[11:10] == 1) ? sp[c] + sp[c] / 10 :
             (rn[11:10] == 2) ? sp[c] - sp[c] / 10 : {9'h0, rn[6:0]};
         meas(p + {14'h0, rn[13:12]} - 16'h1);
      end
      // last sample is kept for the host
      apb(0, 8'h14, 0);
      chk(rd, {16'h0, pval});
      // base variant: two channels, short select ring, narrow selector
      apb(1, 8'h00, 0);
      apb(1, 8'h04, 32'h200);
      @(negedge clk);
      chk({28'h0, relay}, {30'h0, st[1:0]});
      apb(0, 8'h04, 0);
      chk({31'h0, rd[9]}, 0);
      apb(1, 8'h08, 3);
      apb(1, 8'h0C, 32'h5);
      apb(0, 8'h04, 0);
      chk({31'h0, rd[9]}, 1);
      press(0);
      press(0);
      chk({16'h0, display_value}, {16'h0, sp[1]});
      press(0);
      chk({31'h0, display_sp}, 0);
      finish_test;
   end
endmodule
